// ### src/crm_regfile.sv
// Operation
// - data, address, pc, stacks, status, codes, base
// - data registers take bit through quad
// - eighth address register follows privilege stack
// - address registers take word and long only
// - any of sixteen registers may index
// - pc increments or loads
// - status holds flags, mask, control bits
// - levels above the mask, and level seven, are acknowledged
// - control bits select trace and privilege
// - user reaches only the flag byte
// - control registers need supervisor privilege
// - vector address is base plus displacement
// - function code on every access
// - alternate codes come from code registers
// - trap on unimplemented op or mode
// - listed instruction groups are unimplemented
// - seven basic addressing modes
// - postincrement, predecrement, offset and index variants
// - displacement is vector number times four
`timescale 1ns/1ps
`default_nettype none
module crm_regfile (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [crm_pkg::RIW-1:0] wr_idx,
  input wire logic [2:0] wr_size,
  input wire logic [4:0] wr_bit,
  input wire logic [crm_pkg::XLEN-1:0] wr_data,
  input wire logic [crm_pkg::RIW-1:0] wr_idx_ext,
  input wire logic [crm_pkg::XLEN-1:0] wr_data_ext,
  input wire logic [crm_pkg::RIW-1:0] rd_idx,
  output logic [crm_pkg::XLEN-1:0] rd_data_ff,
  input wire logic ea_req,
  input wire logic [3:0] ea_mode,
  input wire logic [2:0] ea_reg,
  input wire logic [crm_pkg::RIW-1:0] ea_idx,
  input wire logic ea_idx_long,
  input wire logic [1:0] ea_scale,
  input wire logic [crm_pkg::XLEN-1:0] ea_disp,
  input wire logic [2:0] ea_size,
  output logic ea_done_ff,
  output logic ea_fault_ff,
  output logic [crm_pkg::XLEN-1:0] ea_addr_ff,
  input wire logic pc_inc,
  input wire logic [3:0] pc_step,
  input wire logic pc_load,
  input wire logic [crm_pkg::XLEN-1:0] pc_value,
  output logic [crm_pkg::XLEN-1:0] program_counter_ff,
  input wire logic sw_wr,
  input wire logic sw_wr_full,
  input wire logic [15:0] sw_wr_data,
  input wire logic ccr_upd,
  input wire logic [crm_pkg::CCR_W-1:0] ccr_in,
  input wire logic exc_enter,
  input wire logic exc_mask_load,
  input wire logic [2:0] exc_mask,
  output logic [15:0] status_word_ff,
  input wire logic [2:0] irq_level,
  output logic irq_take_ff,
  input wire logic ctl_wr,
  input wire logic ctl_rd,
  input wire logic [2:0] ctl_sel,
  input wire logic [crm_pkg::XLEN-1:0] ctl_wdata,
  output logic [crm_pkg::XLEN-1:0] ctl_rdata_ff,
  input wire logic vec_req,
  input wire logic [7:0] vec_num,
  output logic [crm_pkg::XLEN-1:0] vec_addr_ff,
  input wire logic acc_req,
  input wire logic acc_prog,
  input wire logic acc_cpu,
  input wire logic acc_alt_src,
  input wire logic acc_alt_dst,
  output logic fc_valid_ff,
  output logic [2:0] fc_ff,
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  output logic trap_ff,
  output logic [7:0] trap_vec_ff
);
  import crm_pkg::*;

  logic [XLEN-1:0] user_stack_pointer_ff;
  logic [XLEN-1:0] supervisor_stack_pointer_ff;
  logic [XLEN-1:0] vector_table_base_ff;
  logic [2:0] source_space_code_reg_ff;
  logic [2:0] dest_space_code_reg_ff;
  logic sup;
  logic [XLEN-1:0] sp_cur;
  logic [NRD-1:0][RIW-1:0] mem_ridx;
  logic [NRD-1:0][XLEN-1:0] mem_rdata;

  assign sup = status_word_ff[SW_S];
  assign sp_cur = sup ? supervisor_stack_pointer_ff : user_stack_pointer_ff;

  // register write shaping
  logic wr_is_addr;
  logic wr_fault;
  logic wa_en;
  logic quad_en;
  logic [XLEN-1:0] wa_mask;
  logic [XLEN-1:0] wa_data;

  always_comb begin
    wr_is_addr = wr_idx >= IDX_ADDR0;
    wa_mask = '1;
    wa_data = wr_data;
    wr_fault = 1'b0;
    case (wr_size)
      SZ_BIT: begin
        wa_mask = XLEN'(1) << wr_bit;
        wa_data = {XLEN{wr_data[0]}};
        wr_fault = wr_is_addr;
      end
      SZ_BYTE: begin
        wa_mask = XLEN'(MASK_BYTE);
        wr_fault = wr_is_addr;
      end
      SZ_WORD: begin
        if (wr_is_addr) begin
          wa_data = {{16{wr_data[15]}}, wr_data[15:0]};
        end else begin
          wa_mask = XLEN'(MASK_WORD);
        end
      end
      SZ_LONG: begin
        wa_mask = '1;
      end
      SZ_QUAD: begin
        wr_fault = wr_is_addr || wr_idx_ext >= IDX_ADDR0;
      end
      default: begin
        wr_fault = 1'b1;
      end
    endcase
  end

  assign wa_en = wr_en && !wr_fault && wr_idx != IDX_ALIAS;
  assign quad_en = wr_en && !wr_fault && wr_size == SZ_QUAD;

  // effective address stage: reads issued at request, address formed next cycle
  logic s1_v;
  logic [3:0] s1_mode;
  logic [2:0] s1_reg;
  logic s1_idx_alias;
  logic s1_idx_long;
  logic [1:0] s1_scale;
  logic [XLEN-1:0] s1_disp;
  logic [2:0] s1_size;
  logic [XLEN-1:0] s1_pc;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_v <= 1'b0;
      s1_mode <= AM_DREG;
      s1_reg <= '0;
      s1_idx_alias <= 1'b0;
      s1_idx_long <= 1'b0;
      s1_scale <= '0;
      s1_disp <= '0;
      s1_size <= SZ_LONG;
      s1_pc <= '0;
    end else begin
      s1_v <= ea_req;
      if (ea_req) begin
        s1_mode <= ea_mode;
        s1_reg <= ea_reg;
        s1_idx_alias <= ea_idx == IDX_ALIAS;
        s1_idx_long <= ea_idx_long;
        s1_scale <= ea_scale;
        s1_disp <= ea_disp;
        s1_size <= ea_size;
        s1_pc <= program_counter_ff;
      end
    end
  end

  logic [XLEN-1:0] ea_base;
  logic [XLEN-1:0] ea_ix;
  logic [XLEN-1:0] ea_step;
  logic [XLEN-1:0] nxt_ea_addr;
  logic [XLEN-1:0] ea_wb_val;
  logic ea_bad;
  logic ea_upd;

  always_comb begin
    ea_base = (s1_reg == 3'h7) ? sp_cur : mem_rdata[1];
    ea_ix = s1_idx_alias ? sp_cur : mem_rdata[2];
    if (!s1_idx_long) begin
      ea_ix = {{16{ea_ix[15]}}, ea_ix[15:0]};
    end
    ea_ix = ea_ix << s1_scale;
    case (s1_size)
      SZ_BYTE: ea_step = (s1_reg == 3'h7) ? XLEN'(2) : XLEN'(1);
      SZ_WORD: ea_step = XLEN'(2);
      default: ea_step = XLEN'(4);
    endcase
    ea_bad = 1'b0;
    ea_upd = 1'b0;
    ea_wb_val = ea_base;
    nxt_ea_addr = '0;
    case (s1_mode)
      AM_DREG: nxt_ea_addr = '0;
      AM_AREG: ea_bad = s1_size == SZ_BYTE || s1_size == SZ_BIT;
      AM_IND: nxt_ea_addr = ea_base;
      AM_POSTINC: begin
        nxt_ea_addr = ea_base;
        ea_wb_val = ea_base + ea_step;
        ea_upd = 1'b1;
      end
      AM_PREDEC: begin
        nxt_ea_addr = ea_base - ea_step;
        ea_wb_val = ea_base - ea_step;
        ea_upd = 1'b1;
      end
      AM_DISP: nxt_ea_addr = ea_base + s1_disp;
      AM_INDEX: nxt_ea_addr = ea_base + s1_disp + ea_ix;
      AM_PC_DISP: nxt_ea_addr = s1_pc + s1_disp;
      AM_PC_INDEX: nxt_ea_addr = s1_pc + s1_disp + ea_ix;
      AM_ABS: nxt_ea_addr = s1_disp;
      AM_IMM: nxt_ea_addr = s1_pc;
      default: ea_bad = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ea_done_ff <= 1'b0;
      ea_fault_ff <= 1'b0;
      ea_addr_ff <= '0;
    end else begin
      ea_done_ff <= s1_v;
      ea_fault_ff <= s1_v && ea_bad;
      if (s1_v) begin
        ea_addr_ff <= nxt_ea_addr;
      end
    end
  end

  logic ea_wb_mem;
  logic ea_wb_sp;
  assign ea_wb_mem = s1_v && ea_upd && s1_reg != 3'h7;
  assign ea_wb_sp = s1_v && ea_upd && s1_reg == 3'h7;

  // port b: address update has priority over the quad high long
  assign mem_ridx[0] = rd_idx;
  assign mem_ridx[1] = IDX_ADDR0 | RIW'(ea_reg);
  assign mem_ridx[2] = ea_idx;

  crm_gpr_mem #(
    .DEPTH(NGPR),
    .WIDTH(XLEN),
    .AW(RIW),
    .NR(NRD)
  ) u_gpr (
    .clk(clk),
    .arst_n(arst_n),
    .wa_en(wa_en),
    .wa_idx(wr_idx),
    .wa_mask(wa_mask),
    .wa_data(wa_data),
    .wb_en(ea_wb_mem || quad_en),
    .wb_idx(ea_wb_mem ? (IDX_ADDR0 | RIW'(s1_reg)) : wr_idx_ext),
    .wb_data(ea_wb_mem ? ea_wb_val : wr_data_ext),
    .rd_idx(mem_ridx),
    .rd_data(mem_rdata)
  );

  // stack pointers; stack alias writes pick the current privilege
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      user_stack_pointer_ff <= '0;
      supervisor_stack_pointer_ff <= '0;
    end else if (ea_wb_sp || (wr_en && !wr_fault && wr_idx == IDX_ALIAS)) begin
      if (sup) begin
        supervisor_stack_pointer_ff <= ea_wb_sp ? ea_wb_val : wa_data;
      end else begin
        user_stack_pointer_ff <= ea_wb_sp ? ea_wb_val : wa_data;
      end
    end else if (ctl_wr && sup) begin
      if (ctl_sel == CTL_USP) begin
        user_stack_pointer_ff <= ctl_wdata;
      end
      if (ctl_sel == CTL_SSP) begin
        supervisor_stack_pointer_ff <= ctl_wdata;
      end
    end
  end

  // read port; alias value is caught with the request
  logic rd_alias_q;
  logic [XLEN-1:0] rd_sp_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_alias_q <= 1'b0;
      rd_sp_q <= '0;
      rd_data_ff <= '0;
    end else begin
      rd_alias_q <= rd_idx == IDX_ALIAS;
      rd_sp_q <= sp_cur;
      rd_data_ff <= rd_alias_q ? rd_sp_q : mem_rdata[0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      program_counter_ff <= '0;
    end else if (pc_load) begin
      program_counter_ff <= pc_value;
    end else if (pc_inc) begin
      program_counter_ff <= program_counter_ff + XLEN'(pc_step);
    end
  end

  // status word; exception entry outranks software writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_word_ff <= SW_RST;
    end else if (exc_enter) begin
      status_word_ff[SW_S] <= 1'b1;
      status_word_ff[SW_T1] <= 1'b0;
      status_word_ff[SW_T0] <= 1'b0;
      if (exc_mask_load) begin
        status_word_ff[SW_IM_HI:SW_IM_LO] <= exc_mask;
      end
    end else if (sw_wr && sw_wr_full && sup) begin
      status_word_ff <= sw_wr_data & SW_IMPL;
    end else if (sw_wr && !sw_wr_full) begin
      status_word_ff[7:0] <= sw_wr_data[7:0] & SW_IMPL[7:0];
    end else if (ccr_upd) begin
      status_word_ff[CCR_W-1:0] <= ccr_in;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_take_ff <= 1'b0;
    end else begin
      irq_take_ff <= irq_level == IRQ_NMI ||
                     irq_level > status_word_ff[SW_IM_HI:SW_IM_LO];
    end
  end

  // control registers, supervisor only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vector_table_base_ff <= '0;
      source_space_code_reg_ff <= '0;
      dest_space_code_reg_ff <= '0;
    end else if (ctl_wr && sup) begin
      case (ctl_sel)
        CTL_VBR: vector_table_base_ff <= ctl_wdata;
        CTL_SFC: source_space_code_reg_ff <= ctl_wdata[2:0];
        CTL_DFC: dest_space_code_reg_ff <= ctl_wdata[2:0];
        default: vector_table_base_ff <= vector_table_base_ff;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_rdata_ff <= '0;
    end else if (ctl_rd && sup) begin
      case (ctl_sel)
        CTL_USP: ctl_rdata_ff <= user_stack_pointer_ff;
        CTL_SSP: ctl_rdata_ff <= supervisor_stack_pointer_ff;
        CTL_VBR: ctl_rdata_ff <= vector_table_base_ff;
        CTL_SFC: ctl_rdata_ff <= XLEN'(source_space_code_reg_ff);
        CTL_DFC: ctl_rdata_ff <= XLEN'(dest_space_code_reg_ff);
        default: ctl_rdata_ff <= '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vec_addr_ff <= '0;
    end else if (vec_req) begin
      vec_addr_ff <= vector_table_base_ff + (XLEN'(vec_num) << VEC_SHIFT);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fc_valid_ff <= 1'b0;
      fc_ff <= '0;
    end else begin
      fc_valid_ff <= acc_req;
      if (acc_req) begin
        if (acc_alt_src) begin
          fc_ff <= source_space_code_reg_ff;
        end else if (acc_alt_dst) begin
          fc_ff <= dest_space_code_reg_ff;
        end else if (acc_cpu) begin
          fc_ff <= FC_CPU;
        end else begin
          fc_ff <= {sup, acc_prog ? FC_PROG : FC_DATA};
        end
      end
    end
  end

  // table lookup and low-power ops share line f and stay implemented
  function automatic logic [7:0] unimpl_vec(input logic [15:0] op);
    if ((op & OP_LINE_M) == OP_LINEA_V) begin
      return VEC_LINEA;
    end
    if ((op & OP_LINE_M) == OP_LINEF_V && (op & OP_F800_M) != OP_F800_V) begin
      return VEC_LINEF;
    end
    if ((op & OP_BF_M) == OP_BF_V || (op & OP_MOD_M) == OP_MOD_V ||
        ((op & OP_CAS_M) == OP_CAS_V && (op & OP_CAS_SZ) != 16'h0000) ||
        (op & OP_PACK_M) == OP_PACK_V || (op & OP_PACK_M) == OP_UNPK_V) begin
      return VEC_ILLEGAL;
    end
    return VEC_NONE;
  endfunction

  logic [7:0] op_vec;
  logic op_t;
  logic ill_t;
  logic priv_t;
  assign op_vec = unimpl_vec(op_word);
  assign op_t = op_valid && op_vec != VEC_NONE;
  assign ill_t = (s1_v && ea_bad) || (wr_en && wr_fault);
  assign priv_t = (sw_wr && sw_wr_full && !sup) || ((ctl_wr || ctl_rd) && !sup);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trap_ff <= 1'b0;
      trap_vec_ff <= VEC_NONE;
    end else begin
      trap_ff <= op_t || ill_t || priv_t;
      trap_vec_ff <= op_t ? op_vec : ill_t ? VEC_ILLEGAL : priv_t ? VEC_PRIV : VEC_NONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_SP_ALIAS: assert property (rd_idx == IDX_ALIAS |-> ##2 rd_data_ff == $past(sp_cur, 2))
    else $error("stack alias read wrong");
  AST_USER_SW_KEEP: assert property (sw_wr && sw_wr_full && !sup && !exc_enter |=>
    status_word_ff == $past(status_word_ff) && trap_ff)
    else $error("user status write not refused");
  AST_IRQ_MASKED: assert property (irq_level != IRQ_NMI &&
    irq_level <= status_word_ff[SW_IM_HI:SW_IM_LO] |=> !irq_take_ff)
    else $error("masked interrupt taken");
  AST_VEC_ADDR: assert property (vec_req |=>
    vec_addr_ff == $past(vector_table_base_ff) + {22'h0, $past(vec_num), 2'b00})
    else $error("vector address wrong");
  AST_FC_USER_DATA: assert property (acc_req && !acc_alt_src && !acc_alt_dst &&
    !acc_cpu && !acc_prog && !sup |=> fc_valid_ff && fc_ff == 3'h1)
    else $error("user data code wrong");
  AST_FC_ALT: assert property (acc_req && acc_alt_src |=>
    fc_ff == $past(source_space_code_reg_ff))
    else $error("alternate code not used");
  AST_LINEA_TRAP: assert property (op_valid && op_word[15:12] == 4'ha |=>
    trap_ff && trap_vec_ff == VEC_LINEA)
    else $error("line a op not trapped");
  AST_CTL_USER: assert property (ctl_wr && !sup |=>
    $stable(vector_table_base_ff) && trap_ff)
    else $error("user control write accepted");
  AST_PC_INC: assert property (pc_inc && !pc_load |=>
    program_counter_ff == $past(program_counter_ff) + 32'($past(pc_step)))
    else $error("pc increment wrong");
  AST_EA_DONE: assert property (ea_req && !$past(ea_req) && ea_mode == AM_POSTINC |->
    ##1 !ea_done_ff ##1 ea_done_ff)
    else $error("ea answer not in two cycles");
  AST_ADDR_BYTE: assert property (wr_en && wr_idx >= IDX_ADDR0 && wr_size == SZ_BYTE |=>
    trap_ff && trap_vec_ff != VEC_NONE)
    else $error("byte write to address reg allowed");

  COV_PREDEC_SP: cover property (ea_req && ea_mode == AM_PREDEC && ea_reg == 3'h7);
  COV_USER_PRIV: cover property (sw_wr && sw_wr_full && !sup);
  COV_QUAD: cover property (quad_en);
endmodule
`default_nettype wire

// ### include/crm_pkg.sv
`default_nettype none
package crm_pkg;
  localparam int XLEN = 32;
  localparam int NGPR = 15;
  localparam int RIW = 4;
  localparam int NRD = 3;
  localparam logic [3:0] IDX_ADDR0 = 4'h8;
  localparam logic [3:0] IDX_ALIAS = 4'hf;
  // status word layout
  localparam int SW_T1 = 15;
  localparam int SW_T0 = 14;
  localparam int SW_S = 13;
  localparam int SW_IM_HI = 10;
  localparam int SW_IM_LO = 8;
  localparam int CCR_W = 5;
  localparam logic [15:0] SW_RST = 16'h2700;
  localparam logic [15:0] SW_IMPL = 16'he71f;
  localparam logic [2:0] IRQ_NMI = 3'h7;
  // operand sizes
  localparam logic [2:0] SZ_BIT = 3'h0;
  localparam logic [2:0] SZ_BYTE = 3'h1;
  localparam logic [2:0] SZ_WORD = 3'h2;
  localparam logic [2:0] SZ_LONG = 3'h3;
  localparam logic [2:0] SZ_QUAD = 3'h4;
  localparam logic [7:0] MASK_BYTE = 8'hff;
  localparam logic [15:0] MASK_WORD = 16'hffff;
  // addressing modes
  localparam logic [3:0] AM_DREG = 4'h0;
  localparam logic [3:0] AM_AREG = 4'h1;
  localparam logic [3:0] AM_IND = 4'h2;
  localparam logic [3:0] AM_POSTINC = 4'h3;
  localparam logic [3:0] AM_PREDEC = 4'h4;
  localparam logic [3:0] AM_DISP = 4'h5;
  localparam logic [3:0] AM_INDEX = 4'h6;
  localparam logic [3:0] AM_PC_DISP = 4'h7;
  localparam logic [3:0] AM_PC_INDEX = 4'h8;
  localparam logic [3:0] AM_ABS = 4'h9;
  localparam logic [3:0] AM_IMM = 4'ha;
  // function codes; supervisor sets bit 2
  localparam logic [1:0] FC_DATA = 2'h1;
  localparam logic [1:0] FC_PROG = 2'h2;
  localparam logic [2:0] FC_CPU = 3'h7;
  // control register selects
  localparam logic [2:0] CTL_USP = 3'h0;
  localparam logic [2:0] CTL_SSP = 3'h1;
  localparam logic [2:0] CTL_VBR = 3'h2;
  localparam logic [2:0] CTL_SFC = 3'h3;
  localparam logic [2:0] CTL_DFC = 3'h4;
  // exception vectors
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_PRIV = 8'h08;
  localparam logic [7:0] VEC_LINEA = 8'h0a;
  localparam logic [7:0] VEC_LINEF = 8'h0b;
  localparam int VEC_SHIFT = 2;
  // unimplemented opcode groups, mask and match
  localparam logic [15:0] OP_LINE_M = 16'hf000;
  localparam logic [15:0] OP_LINEA_V = 16'ha000;
  localparam logic [15:0] OP_LINEF_V = 16'hf000;
  localparam logic [15:0] OP_F800_M = 16'hffc0;
  localparam logic [15:0] OP_F800_V = 16'hf800;
  localparam logic [15:0] OP_BF_M = 16'hf8c0;
  localparam logic [15:0] OP_BF_V = 16'he8c0;
  localparam logic [15:0] OP_MOD_M = 16'hffc0;
  localparam logic [15:0] OP_MOD_V = 16'h06c0;
  localparam logic [15:0] OP_CAS_M = 16'hf9c0;
  localparam logic [15:0] OP_CAS_V = 16'h08c0;
  localparam logic [15:0] OP_CAS_SZ = 16'h0600;
  localparam logic [15:0] OP_PACK_M = 16'hf1f0;
  localparam logic [15:0] OP_PACK_V = 16'h8140;
  localparam logic [15:0] OP_UNPK_V = 16'h8180;
endpackage
`default_nettype wire

// ### src/crm_gpr_mem.sv
`timescale 1ns/1ps
`default_nettype none
module crm_gpr_mem #(
  parameter int DEPTH = 15,
  parameter int WIDTH = 32,
  parameter int AW = 4,
  parameter int NR = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wa_en,
  input wire logic [AW-1:0] wa_idx,
  input wire logic [WIDTH-1:0] wa_mask,
  input wire logic [WIDTH-1:0] wa_data,
  input wire logic wb_en,
  input wire logic [AW-1:0] wb_idx,
  input wire logic [WIDTH-1:0] wb_data,
  input wire logic [NR-1:0][AW-1:0] rd_idx,
  output logic [NR-1:0][WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // port b is applied last and wins on a shared index
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem <= '{default: '0};
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (wa_en && wa_idx == AW'(i)) begin
          mem[i] <= (mem[i] & ~wa_mask) | (wa_data & wa_mask);
        end
        if (wb_en && wb_idx == AW'(i)) begin
          mem[i] <= wb_data;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else begin
      for (int r = 0; r < NR; r++) begin
        rd_data[r] <= (32'(rd_idx[r]) < DEPTH) ? mem[rd_idx[r]] : '0;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/crm_exec_model.sv
`timescale 1ns/1ps
`default_nettype none
module crm_exec_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] op_sel,
  output logic op_valid,
  output logic [15:0] op_word
);
  logic [15:0] tbl [6];
  initial begin
    tbl = '{16'ha000, 16'hf000, 16'he8c0, 16'h06c0, 16'h0ac0, 16'h8140};
    op_valid = 1'b0;
    op_word = 16'h0000;
  end
  // idle word toggles so a stale opcode never looks fresh
  always @(posedge clk) begin
    op_valid <= go;
    op_word <= go ? tbl[op_sel] : ~op_word;
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import crm_pkg::*;
  logic clk, arst_n, wr_en, ea_req, ea_idx_long, pc_inc, pc_load, sw_wr, sw_wr_full, ccr_upd;
  logic exc_enter, exc_mask_load, ctl_wr, ctl_rd, vec_req, acc_req, acc_prog, acc_cpu;
  logic acc_alt_src, acc_alt_dst, op_valid, go, ea_done_ff, ea_fault_ff, irq_take_ff;
  logic fc_valid_ff, trap_ff;
  logic [3:0] wr_idx, wr_idx_ext, rd_idx, ea_mode, ea_idx, pc_step, op_sel;
  logic [2:0] wr_size, ea_reg, ea_size, exc_mask, irq_level, ctl_sel, fc_ff;
  logic [4:0] wr_bit, ccr_in;
  logic [1:0] ea_scale;
  logic [7:0] vec_num, trap_vec_ff;
  logic [15:0] sw_wr_data, op_word, status_word_ff;
  logic [31:0] wr_data, wr_data_ext, ea_disp, pc_value, ctl_wdata;
  logic [31:0] rd_data_ff, ea_addr_ff, program_counter_ff, ctl_rdata_ff, vec_addr_ff;
  int num_errors, n_tests;
  crm_regfile crm_regfile_i (.*);
  crm_exec_model crm_exec_model_i (.clk, .go, .op_sel, .op_valid, .op_word);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] i, input logic [2:0] s, input logic [31:0] d,
                    input logic [3:0] xi, input logic [31:0] xd);
    @(posedge clk);
    wr_en <= 1'b1; wr_idx <= i; wr_size <= s; wr_bit <= 5'h1f; wr_data <= d;
    wr_idx_ext <= xi; wr_data_ext <= xd;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] i, input logic [31:0] e);
    @(posedge clk);
    rd_idx <= i;
    repeat (3) @(posedge clk);
    #1 chk(rd_data_ff, e);
  endtask
  task automatic ctl(input logic w, input logic [2:0] s, input logic [31:0] d);
    @(posedge clk);
    ctl_wr <= w; ctl_rd <= !w; ctl_sel <= s; ctl_wdata <= d;
    @(posedge clk);
    ctl_wr <= 1'b0; ctl_rd <= 1'b0;
    #1;
  endtask
  task automatic sw(input logic full, input logic [15:0] d);
    @(posedge clk);
    sw_wr <= 1'b1; sw_wr_full <= full; sw_wr_data <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
    #1;
  endtask
  task automatic trap_is(input logic [7:0] v);
    chk(32'(trap_ff), 32'h1);
    chk(32'(trap_vec_ff), 32'(v));
  endtask
  task automatic ea(input logic [3:0] m);
    @(posedge clk);
    ea_req <= 1'b1; ea_mode <= m; ea_reg <= 3'h2; ea_size <= SZ_LONG;
    @(posedge clk);
    ea_req <= 1'b0;
    @(posedge clk);
    #1 chk(32'(ea_done_ff), 32'h1);
  endtask
  task automatic t_data;
    chk(32'(status_word_ff), 32'h2700);
    wr(4'h2, SZ_LONG, 32'h11223344, 4'h0, 32'h0);
    wr(4'h2, SZ_BYTE, 32'h000000ab, 4'h0, 32'h0);
    wr(4'h2, SZ_BIT, 32'h1, 4'h0, 32'h0);
    rd(4'h2, 32'h912233ab);
    wr(4'h3, SZ_QUAD, 32'h5, 4'h4, 32'h6);
    rd(4'h3, 32'h5);
    rd(4'h4, 32'h6);
    wr(4'h9, SZ_BIT, 32'h1, 4'h0, 32'h0);
    trap_is(VEC_ILLEGAL);
  endtask
  task automatic t_super;
    wr(IDX_ALIAS, SZ_LONG, 32'h1234, 4'h0, 32'h0);
    ctl(1'b0, CTL_SSP, 32'h0);
    chk(ctl_rdata_ff, 32'h1234);
    ctl(1'b0, CTL_USP, 32'h0);
    chk(ctl_rdata_ff, 32'h0);
    ctl(1'b1, CTL_VBR, 32'h100);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      vec_req <= 1'b1; vec_num <= k ? 8'hff : 8'h05;
      @(posedge clk);
      vec_req <= 1'b0;
      #1 chk(vec_addr_ff, k ? 32'h4fc : 32'h114);
    end
    wr(4'ha, SZ_LONG, 32'h1000, 4'h0, 32'h0);
    ea(AM_POSTINC);
    chk(ea_addr_ff, 32'h1000);
    rd(4'ha, 32'h1004);
    @(posedge clk);
    ea_idx <= 4'h3; ea_scale <= 2'h2; ea_disp <= 32'h10;
    ea(AM_INDEX);
    chk(ea_addr_ff, 32'h1028);
    ea(4'hf);
    chk(32'(ea_fault_ff), 32'h1);
    @(posedge clk);
    pc_load <= 1'b1; pc_value <= 32'h100;
    @(posedge clk);
    pc_load <= 1'b0; pc_inc <= 1'b1; pc_step <= 4'h2;
    @(posedge clk);
    pc_inc <= 1'b0;
    #1 chk(program_counter_ff, 32'h102);
  endtask
  task automatic t_ops;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      go <= 1'b1; op_sel <= 4'(k);
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1 chk(32'(trap_ff), 32'h1);
      chk(32'(trap_vec_ff),
          32'(k == 0 ? VEC_LINEA : k == 1 ? VEC_LINEF : VEC_ILLEGAL));
    end
  endtask
  task automatic irq(input logic [2:0] l, input logic e);
    @(posedge clk);
    irq_level <= l;
    repeat (2) @(posedge clk);
    #1 chk(32'(irq_take_ff), 32'(e));
  endtask
  task automatic t_user;
    irq(3'h6, 1'b0);
    irq(IRQ_NMI, 1'b1);
    sw(1'b1, 16'h0003);
    chk(32'(status_word_ff), 32'h0003);
    irq(3'h1, 1'b1);
    sw(1'b0, 16'h2711);
    chk(32'(status_word_ff), 32'h0011);
    sw(1'b1, 16'h2700);
    trap_is(VEC_PRIV);
    chk(32'(status_word_ff), 32'h0011);
    ctl(1'b0, CTL_VBR, 32'h0);
    trap_is(VEC_PRIV);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      acc_req <= 1'b1; acc_cpu <= 1'(k);
      @(posedge clk);
      acc_req <= 1'b0;
      #1 chk(32'(fc_ff), k ? 32'(FC_CPU) : 32'(FC_DATA));
      chk(32'(fc_valid_ff), 32'h1);
    end
    wr(IDX_ALIAS, SZ_LONG, 32'h55, 4'h0, 32'h0);
    rd(IDX_ALIAS, 32'h55);
    @(posedge clk);
    ccr_upd <= 1'b1; ccr_in <= 5'h1f;
    @(posedge clk);
    ccr_upd <= 1'b0; exc_enter <= 1'b1; exc_mask_load <= 1'b1; exc_mask <= 3'h5;
    @(posedge clk);
    exc_enter <= 1'b0;
    #1 chk(32'(status_word_ff), 32'h251f);
  endtask
  // mid-run reset must bring back supervisor state and clear the registers
  task automatic t_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk(32'(status_word_ff), 32'(SW_RST));
    chk(program_counter_ff, 32'h0);
    chk(vec_addr_ff, 32'h0);
    chk(32'(trap_ff), 32'h0);
    rd(4'h2, 32'h0);
  endtask
  initial begin
    {arst_n, wr_en, ea_req, ea_idx_long, pc_inc, pc_load, sw_wr, sw_wr_full, ccr_upd} = '0;
    {exc_enter, exc_mask_load, ctl_wr, ctl_rd, vec_req, acc_req, acc_prog, acc_cpu} = '0;
    {acc_alt_src, acc_alt_dst, go, wr_idx, wr_idx_ext, rd_idx, ea_mode, ea_idx} = '0;
    {pc_step, op_sel, wr_size, ea_reg, ea_size, exc_mask, irq_level, ctl_sel} = '0;
    {wr_bit, ccr_in, ea_scale, vec_num, sw_wr_data, wr_data, wr_data_ext} = '0;
    {ea_disp, pc_value, ctl_wdata, num_errors, n_tests} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_data();
    t_super();
    t_ops();
    t_user();
    t_reset();
    tally_and_finish();
  end
  initial begin
    #100us;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
